// ==== verilog/fmau_cfg.svh ====
// Constants for the fused multiply-add unit: codes, exponent limits, windows.
// Assumes operands and results are held in the 64-bit double register format.
`ifndef FMAU_CFG_SVH
`define FMAU_CFG_SVH

// ==========================================================================
// Rounding-mode field codes
`define FMAU_RM_NEAR      2'h0
`define FMAU_RM_ZERO      2'h1
`define FMAU_RM_PINF      2'h2
`define FMAU_RM_NINF      2'h3

// ==========================================================================
// Exponent bias and limits (unbiased, 13-bit signed)
`define FMAU_BIAS         13'sh03FF
`define FMAU_DBL_EMIN     (-13'sh03FE)
`define FMAU_DBL_EMAX     13'sh03FF
`define FMAU_SGL_EMIN     (-13'sh007E)
`define FMAU_SGL_EMAX     13'sh007F
`define FMAU_EXP_ONES     11'h7FF

// ==========================================================================
// Datapath window and rounding positions
`define FMAU_WIN          164
`define FMAU_LZW          8
`define FMAU_SH_CAP       13'sh00A4
`define FMAU_SGL_LSB      29
`define FMAU_QNAN_BIT     51
`define FMAU_DEF_QNAN     64'h7FF8000000000000
`define FMAU_SGL_MAXFRAC  52'hFFFFFE0000000
`define FMAU_DBL_MAXFRAC  52'hFFFFFFFFFFFFF

// ==========================================================================
// Result-class field codes
`define FMAU_CLS_QNAN     5'h11
`define FMAU_CLS_NINF     5'h09
`define FMAU_CLS_NNORM    5'h08
`define FMAU_CLS_NZERO    5'h12
`define FMAU_CLS_PZERO    5'h02
`define FMAU_CLS_PNORM    5'h04
`define FMAU_CLS_PINF     5'h05

`endif

// ==== verilog/fmau_pkg.sv ====
// Types shared by the fused multiply-add unit and its bench.
// Assumes nothing beyond the double register format.
package fmau_pkg;

	// ======================================================================
	// Operation variants
	typedef enum logic [1:0] {
		FMAU_MADD,
		FMAU_MSUB,
		FMAU_NMADD,
		FMAU_NMSUB
	} fmau_op_e;

	// ======================================================================
	// Request bundle: all three sources arrive with the variant together.
	typedef struct packed {
		fmau_op_e    op;
		logic        single;
		logic        rec;
		logic [63:0] a;
		logic [63:0] b;
		logic [63:0] c;
	} fmau_req_s;

	// Exception events of one operation.
	typedef struct packed {
		logic vxsnan;
		logic vximz;
		logic vxisi;
		logic ox;
		logic ux;
		logic xx;
	} fmau_exc_s;

	// Unpacked operand.
	typedef struct packed {
		logic               sign;
		logic signed [12:0] exp;
		logic [52:0]        man;
		logic               nan;
		logic               snan;
		logic               inf;
		logic               zero;
	} fmau_unp_s;

endpackage

// ==== verilog/fmau_norm.sv ====
// Leading-zero counter and left normaliser for the adder window.
// Assumes a zero input is handled by the caller; it then reports a count of 0.
module fmau_norm #(
	parameter int W  = 164,
	parameter int LW = 8
) (
	input  wire logic [W-1:0]  val,
	output logic      [W-1:0]  nrm,
	output logic      [LW-1:0] lz
);

	// ======================================================================
	// Elaboration check
	if (W < 2 || (1 << LW) < W)
	begin : g_bad
		$error("fmau_norm: count width too small for window");
	end

	// ======================================================================
	// Count and shift
	always_comb
	begin
		lz = '0;
		// The highest set bit is seen last, so it decides the count.
		for (int i = 0; i < W; i++)
		begin
			if (val[i])
			begin
				lz = LW'(W - 1 - i);
			end
		end
		nrm = val << lz;
	end

endmodule

// ==== verilog/fmau_core.sv ====
// Fused multiply-add unit: A*C +/- B, optional negation, single or double target.
// Assumes the sequencer holds rounding mode and invalid enable stable on the
// same clock, and takes the one-cycle completion pulse with its results.
//
// Operation
// RULE_01: Multiply first and third source operands.
// RULE_02: Add variants sum addend with product.
// RULE_03: Subtract variants subtract addend from product.
// RULE_04: Renormalise when leading significand bit zero.
// RULE_05: Round to single or double target.
// RULE_06: Rounding mode field selects direction.
// RULE_07: Negative forms negate the rounded result.
// RULE_08: Write class field unless enabled invalid.
// RULE_09: Record flag updates condition field only.
// RULE_10: Propagated quiet NaN keeps its sign.
// RULE_11: Generated default NaN has sign zero.
// RULE_12: Quieted signalling NaN keeps its sign.
// RULE_13: One fused operation, product never rounded.
// RULE_14: All 106 product bits reach adder.
// RULE_15: Sequencer presents operands together, takes results.
`include "fmau_cfg.svh"

module fmau_core (
	input  wire logic               clk,
	input  wire logic               srst,
	input  wire logic               req_valid,
	input  wire fmau_pkg::fmau_req_s req,
	input  wire logic [1:0]         rounding_mode_field,
	input  wire logic               invalid_op_enable,
	output logic                    done,
	output logic [63:0]             dest_fp_reg,
	output logic                    dest_we,
	output logic [4:0]              result_class_field,
	output logic                    class_we,
	output logic [3:0]              condition_reg,
	output logic                    cr_we,
	output fmau_pkg::fmau_exc_s     exc_flags
);

	localparam int W  = `FMAU_WIN;
	localparam int LW = `FMAU_LZW;

	// ======================================================================
	// Helpers
	function automatic fmau_pkg::fmau_unp_s unpack(input logic [63:0] x);
		fmau_pkg::fmau_unp_s u;
		logic                ez;
		logic                eo;
		ez     = (x[62:52] == 11'h000);
		eo     = (x[62:52] == `FMAU_EXP_ONES);
		u.sign = x[63];
		u.exp  = ez ? `FMAU_DBL_EMIN : ($signed({2'h0, x[62:52]}) - `FMAU_BIAS);
		u.man  = {~ez, x[51:0]};
		u.inf  = eo && (x[51:0] == 52'h0);
		u.nan  = eo && (x[51:0] != 52'h0);
		u.snan = u.nan && !x[`FMAU_QNAN_BIT];
		u.zero = ez && (x[51:0] == 52'h0);
		return u;
	endfunction

	// Right shift that folds every bit shifted out into the lowest bit.
	function automatic logic [W-1:0] shr_st(input logic [W-1:0] x, input logic [LW-1:0] sh);
		logic [2*W-1:0] t;
		t = {x, {W{1'b0}}} >> sh;
		return {t[2*W-1:W+1], t[W] | (|t[W-1:0])};
	endfunction

	// ======================================================================
	// Operand decode
	fmau_pkg::fmau_unp_s ua;
	fmau_pkg::fmau_unp_s ub;
	fmau_pkg::fmau_unp_s uc;
	logic                is_sub;
	logic                is_neg;
	logic                sp;
	logic                sb;

	always_comb
	begin
		ua     = unpack(req.a);
		ub     = unpack(req.b);
		uc     = unpack(req.c);
		// RULE_03: subtract flips addend
		is_sub = (req.op == fmau_pkg::FMAU_MSUB) || (req.op == fmau_pkg::FMAU_NMSUB);
		is_neg = (req.op == fmau_pkg::FMAU_NMADD) || (req.op == fmau_pkg::FMAU_NMSUB);
		sp     = ua.sign ^ uc.sign;
		sb     = ub.sign ^ is_sub;
	end

	// ======================================================================
	// Exact product and alignment
	logic [105:0]       prod;
	logic signed [12:0] ep;
	logic signed [12:0] emax;
	logic signed [12:0] shp;
	logic signed [12:0] shb;
	logic [W-1:0]       win_p;
	logic [W-1:0]       win_b;

	always_comb
	begin
		// RULE_01: full product A times C
		prod  = ua.man * uc.man;
		ep    = ua.exp + uc.exp + 13'sh0001;
		emax  = (ep > ub.exp) ? ep : ub.exp;
		shp   = emax - ep;
		shb   = emax - ub.exp;
		if (shp > `FMAU_SH_CAP)
		begin
			shp = `FMAU_SH_CAP;
		end
		if (shb > `FMAU_SH_CAP)
		begin
			shb = `FMAU_SH_CAP;
		end
		// RULE_13 RULE_14: unrounded 106 bits
		win_p = shr_st({1'b0, prod, 57'h0}, shp[LW-1:0]);
		win_b = shr_st({1'b0, ub.man, 110'h0}, shb[LW-1:0]);
	end

	// ======================================================================
	// Add or subtract magnitudes
	logic [W-1:0] mag;
	logic         msign;

	always_comb
	begin
		if (sp == sb)
		begin
			// RULE_02: same signs add
			mag   = win_p + win_b;
			msign = sp;
		end
		else if (win_p >= win_b)
		begin
			mag   = win_p - win_b;
			msign = sp;
		end
		else
		begin
			mag   = win_b - win_p;
			msign = sb;
		end
		// An exact zero sum of opposite-signed terms takes minus only when rounding toward minus.
		if (mag == '0 && sp != sb)
		begin
			msign = (rounding_mode_field == `FMAU_RM_NINF);
		end
	end

	// ======================================================================
	// Normalise
	logic [W-1:0]  nrm;
	logic [LW-1:0] lz;

	// RULE_04: shift leading one up
	fmau_norm #(
		.W  (W),
		.LW (LW)
	) u_norm (
		.val (mag),
		.nrm (nrm),
		.lz  (lz)
	);

	// ======================================================================
	// Round
	logic [52:0]        mant;
	logic               gbit;
	logic               sbit;
	logic               inc;
	logic [53:0]        rsum;
	logic signed [12:0] e_r;
	logic signed [12:0] emin_f;
	logic signed [12:0] emax_f;
	logic [51:0]        frac;
	logic               ovf;
	logic               unf;
	logic               huge_sat;

	always_comb
	begin
		// RULE_05: precision picks guard position
		if (req.single)
		begin
			mant   = {nrm[W-1:W-24], 29'h0};
			gbit   = nrm[W-25];
			sbit   = |nrm[W-26:0];
			emin_f = `FMAU_SGL_EMIN;
			emax_f = `FMAU_SGL_EMAX;
		end
		else
		begin
			mant   = nrm[W-1:W-53];
			gbit   = nrm[W-54];
			sbit   = |nrm[W-55:0];
			emin_f = `FMAU_DBL_EMIN;
			emax_f = `FMAU_DBL_EMAX;
		end
		// RULE_06: direction from mode field
		case (rounding_mode_field)
			`FMAU_RM_NEAR: inc = gbit && (sbit || mant[req.single ? `FMAU_SGL_LSB : 0]);
			`FMAU_RM_ZERO: inc = 1'b0;
			`FMAU_RM_PINF: inc = !msign && (gbit || sbit);
			default:       inc = msign && (gbit || sbit);
		endcase
		rsum = {1'b0, mant} + (inc ? (req.single ? 54'h20000000 : 54'h1) : 54'h0);
		e_r  = emax + 13'sh0001 - $signed({5'h00, lz});
		if (rsum[53])
		begin
			frac = rsum[52:1];
			e_r  = e_r + 13'sh0001;
		end
		else
		begin
			frac = rsum[51:0];
		end
		ovf = (mag != '0) && (e_r > emax_f);
		// Tiny results flush to zero: no gradual underflow is produced.
		unf = (mag != '0) && (e_r < emin_f);
		huge_sat = (rounding_mode_field == `FMAU_RM_ZERO)
			|| (rounding_mode_field == `FMAU_RM_PINF && msign)
			|| (rounding_mode_field == `FMAU_RM_NINF && !msign);
	end

	// ======================================================================
	// Special operands and result assembly
	logic              any_nan;
	logic              imz;
	logic              isi;
	logic              inval;
	logic [63:0]       res;
	logic              res_nan;
	logic              res_inf;
	logic              res_zero;
	logic [4:0]        cls;
	fmau_pkg::fmau_exc_s exc;

	always_comb
	begin
		any_nan    = ua.nan || ub.nan || uc.nan;
		imz        = !any_nan && ((ua.inf && uc.zero) || (ua.zero && uc.inf));
		isi        = !any_nan && !imz && (ua.inf || uc.inf) && ub.inf && (sp != sb);
		exc.vxsnan = ua.snan || ub.snan || uc.snan;
		exc.vximz  = imz;
		exc.vxisi  = isi;
		inval      = exc.vxsnan || imz || isi;
		exc.ox     = 1'b0;
		exc.ux     = 1'b0;
		exc.xx     = 1'b0;
		res_nan    = 1'b0;
		res_inf    = 1'b0;
		res_zero   = 1'b0;
		if (any_nan)
		begin
			// RULE_10 RULE_12: NaN sign kept
			res     = ua.nan ? req.a : (ub.nan ? req.b : req.c);
			res[`FMAU_QNAN_BIT] = 1'b1;
			res_nan = 1'b1;
		end
		else if (imz || isi)
		begin
			// RULE_11: default NaN positive
			res     = `FMAU_DEF_QNAN;
			res_nan = 1'b1;
		end
		else if (ua.inf || uc.inf || ub.inf)
		begin
			res     = {(ua.inf || uc.inf) ? sp : sb, `FMAU_EXP_ONES, 52'h0};
			res_inf = 1'b1;
		end
		else if (mag == '0 || unf)
		begin
			res      = {msign, 63'h0};
			res_zero = 1'b1;
			exc.ux   = unf;
			exc.xx   = unf;
		end
		else if (ovf)
		begin
			exc.ox = 1'b1;
			exc.xx = 1'b1;
			if (huge_sat)
			begin
				res = {msign, 11'(emax_f + `FMAU_BIAS),
					req.single ? `FMAU_SGL_MAXFRAC : `FMAU_DBL_MAXFRAC};
			end
			else
			begin
				res     = {msign, `FMAU_EXP_ONES, 52'h0};
				res_inf = 1'b1;
			end
		end
		else
		begin
			res    = {msign, 11'(e_r + `FMAU_BIAS), frac};
			exc.xx = gbit || sbit;
		end
		// Single NaN payloads are cut to the single fraction width.
		if (res_nan && req.single)
		begin
			res[`FMAU_SGL_LSB-1:0] = '0;
		end
		// RULE_07: negate after rounding
		if (is_neg && !res_nan)
		begin
			res[63] = !res[63];
		end
		if (res_nan)
		begin
			cls = `FMAU_CLS_QNAN;
		end
		else if (res_inf)
		begin
			cls = res[63] ? `FMAU_CLS_NINF : `FMAU_CLS_PINF;
		end
		else if (res_zero)
		begin
			cls = res[63] ? `FMAU_CLS_NZERO : `FMAU_CLS_PZERO;
		end
		else
		begin
			cls = res[63] ? `FMAU_CLS_NNORM : `FMAU_CLS_PNORM;
		end
	end

	// ======================================================================
	// Result registers
	logic                done_d;
	logic                done_q;
	logic [63:0]         dest_d;
	logic [63:0]         dest_q;
	logic                dwe_d;
	logic                dwe_q;
	logic [4:0]          cls_d;
	logic [4:0]          cls_q;
	logic                cwe_d;
	logic                cwe_q;
	logic [3:0]          cr_d;
	logic [3:0]          cr_q;
	logic                crwe_d;
	logic                crwe_q;
	fmau_pkg::fmau_exc_s exc_d;
	fmau_pkg::fmau_exc_s exc_q;
	logic                trap;
	logic                any_exc;

	always_comb
	begin
		// RULE_15: operands taken on valid
		trap    = inval && invalid_op_enable;
		any_exc = inval || exc.ox || exc.ux || exc.xx;
		done_d  = req_valid;
		dwe_d   = req_valid && !trap;
		dest_d  = req_valid ? res : dest_q;
		// RULE_08: class skipped on trap
		cwe_d   = req_valid && !trap;
		cls_d   = (req_valid && !trap) ? cls : cls_q;
		// RULE_09: record flag gates update
		crwe_d  = req_valid && req.rec;
		cr_d    = (req_valid && req.rec) ? {any_exc, trap, inval, exc.ox} : cr_q;
		exc_d   = req_valid ? exc : '0;
	end

	always_ff @(posedge clk)
	begin
		if (srst)
		begin
			done_q <= 1'b0;
			dest_q <= 64'h0;
			dwe_q  <= 1'b0;
			cls_q  <= 5'h00;
			cwe_q  <= 1'b0;
			cr_q   <= 4'h0;
			crwe_q <= 1'b0;
			exc_q  <= '0;
		end
		else
		begin
			done_q <= done_d;
			dest_q <= dest_d;
			dwe_q  <= dwe_d;
			cls_q  <= cls_d;
			cwe_q  <= cwe_d;
			cr_q   <= cr_d;
			crwe_q <= crwe_d;
			exc_q  <= exc_d;
		end
	end

	assign done               = done_q;
	assign dest_fp_reg        = dest_q;
	assign dest_we            = dwe_q;
	assign result_class_field = cls_q;
	assign class_we           = cwe_q;
	assign condition_reg      = cr_q;
	assign cr_we              = crwe_q;
	assign exc_flags          = exc_q;

endmodule

// ==== tb/fmau_checker.sv ====
// Concurrent checks on the ports of the fused multiply-add unit.
// Assumes the package and the constant header are compiled ahead of it.
`include "fmau_cfg.svh"

module fmau_checker (
	input wire logic                clk,
	input wire logic                srst,
	input wire logic                req_valid,
	input wire fmau_pkg::fmau_req_s req,
	input wire logic [1:0]          rounding_mode_field,
	input wire logic                invalid_op_enable,
	input wire logic                done,
	input wire logic [63:0]         dest_fp_reg,
	input wire logic                dest_we,
	input wire logic [4:0]          result_class_field,
	input wire logic                class_we,
	input wire logic [3:0]          condition_reg,
	input wire logic                cr_we,
	input wire fmau_pkg::fmau_exc_s exc_flags
);
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (srst);

	function automatic logic is_nan(logic [63:0] v);
		return v[62:52] == `FMAU_EXP_ONES && v[51:0] != 52'h0;
	endfunction

	function automatic logic is_fin(logic [63:0] v);
		return v[62:52] != `FMAU_EXP_ONES && v[62:0] != 63'h0;
	endfunction

	logic inv;
	logic no_nan;
	assign inv = exc_flags.vxsnan | exc_flags.vximz | exc_flags.vxisi;
	assign no_nan = !is_nan(req.a) && !is_nan(req.b) && !is_nan(req.c);

	// ======================================================================
	// Assertions
	a_done_follows_req: assert property (req_valid |=> done)
		else $error("done missing after request");
	a_done_has_cause: assert property (done |-> $past(req_valid))
		else $error("done without request");
	a_record_write: assert property (req_valid |=> cr_we == $past(req.rec))
		else $error("cr_we disagrees with record flag");
	a_cond_holds: assert property (!cr_we |-> $stable(condition_reg))
		else $error("condition_reg moved without cr_we");
	a_class_holds: assert property (!class_we |-> $stable(result_class_field))
		else $error("class field moved without class_we");
	a_trap_blocks: assert property (done && inv && $past(invalid_op_enable) |-> !class_we && !dest_we)
		else $error("trapped invalid still wrote");
	a_normal_writes: assert property (done && !inv |-> class_we && dest_we)
		else $error("clean result not written");
	a_qnan_sign: assert property (req_valid && req.op[1] && is_nan(req.a) && req.a[51]
		|=> dest_fp_reg[63:51] == $past(req.a[63:51]))
		else $error("propagated quiet NaN changed");
	a_snan_sign: assert property (req_valid && is_nan(req.a) && !req.a[51]
		|=> dest_fp_reg[63] == $past(req.a[63]) && dest_fp_reg[51])
		else $error("quieted signalling NaN sign lost");
	a_default_nan: assert property (req_valid && no_nan && !invalid_op_enable
		&& req.a[62:0] == 63'h7FF0000000000000 && req.c[62:0] == 63'h0
		|=> dest_fp_reg == `FMAU_DEF_QNAN)
		else $error("generated NaN not default");
	a_neg_sign: assert property (req_valid && is_fin(req.a) && is_fin(req.c)
		&& req.b[62:0] == 63'h0
		|=> dest_fp_reg[63] == $past(req.a[63] ^ req.c[63] ^ req.op[1]))
		else $error("result sign wrong");

	c_record: cover property (req_valid && req.rec);
	c_trap: cover property (done && !dest_we);
	c_back_to_back: cover property (req_valid [*2]);
endmodule

bind fmau_core fmau_checker fmau_checker_inst (.clk, .srst, .req_valid, .req,
	.rounding_mode_field, .invalid_op_enable, .done, .dest_fp_reg, .dest_we,
	.result_class_field, .class_we, .condition_reg, .cr_we, .exc_flags);

// ==== tb/fmau_seq.sv ====
// Sequencer model that presents requests to the fused multiply-add unit.
// Assumes the caller collects each result one cycle after the request.
module fmau_seq (
	input  wire logic           clk,
	output logic                req_valid,
	output fmau_pkg::fmau_req_s req,
	output logic [1:0]          rounding_mode_field,
	output logic                invalid_op_enable
);
	timeunit 1ns;
	timeprecision 1ps;

	initial
	begin
		req_valid = 1'h0;
		req = '0;
		rounding_mode_field = 2'h0;
		invalid_op_enable = 1'h0;
	end

	task automatic send(input fmau_pkg::fmau_req_s r, input logic [1:0] rm, input logic ve);
		@(posedge clk);
		req_valid <= 1'h1;
		req <= r;
		rounding_mode_field <= rm;
		invalid_op_enable <= ve;
	endtask

	// Stale operands are inverted so a design reading them outside a request shows up.
	task automatic idle();
		@(posedge clk);
		req_valid <= 1'h0;
		req <= fmau_pkg::fmau_req_s'(~req);
		rounding_mode_field <= ~rounding_mode_field;
		invalid_op_enable <= ~invalid_op_enable;
	endtask
endmodule

// ==== tb/tb.sv ====
// Self-checking bench for the fused multiply-add unit.
// Assumes the checker is bound to the core and the sequencer model drives it.
`define CHK(n, e, g) begin num_checks++; if ((g) !== (e)) begin n_mismatch++; \
	$display("ERROR %s exp %h got %h", n, e, g); end end

module tb;
	timeunit 1ns;
	timeprecision 1ps;

	logic                clk = 1'h0;
	logic                srst = 1'h1;
	logic                req_valid;
	fmau_pkg::fmau_req_s req;
	logic [1:0]          rm;
	logic                ve;
	logic                done;
	logic [63:0]         res;
	logic                dest_we;
	logic [4:0]          cls;
	logic                class_we;
	logic [3:0]          cond;
	logic                cr_we;
	fmau_pkg::fmau_exc_s exc;
	int                  n_mismatch = 0;
	int                  num_checks = 0;

	always #4 clk = ~clk;

	fmau_seq fmau_seq_inst (.clk(clk), .req_valid(req_valid), .req(req),
		.rounding_mode_field(rm), .invalid_op_enable(ve));

	fmau_core fmau_core_inst (.clk(clk), .srst(srst), .req_valid(req_valid), .req(req),
		.rounding_mode_field(rm), .invalid_op_enable(ve), .done(done), .dest_fp_reg(res),
		.dest_we(dest_we), .result_class_field(cls), .class_we(class_we),
		.condition_reg(cond), .cr_we(cr_we), .exc_flags(exc));

	task automatic end_sim();
		$display("checks %0d mismatches %0d", num_checks, n_mismatch);
		if (n_mismatch == 0 && num_checks > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask

	// A done pulse still missing after four more cycles ends the run.
	task automatic wait_done();
		#1;
		for (int i = 0; i < 4 && done !== 1'h1; i++)
		begin
			@(posedge clk);
			#1;
		end
		if (done !== 1'h1)
		begin
			n_mismatch++;
			end_sim();
		end
	endtask

	task automatic run(input fmau_pkg::fmau_op_e op, input logic sg, rc,
		input logic [63:0] a, b, c, input logic [1:0] m, input logic e);
		fmau_seq_inst.send('{op, sg, rc, a, b, c}, m, e);
		fmau_seq_inst.idle();
		wait_done();
	endtask

	// ======================================================================
	// Scenarios
	task automatic t_basic();
		run(fmau_pkg::FMAU_MADD, 1'h0, 1'h0, 64'h3FF8000000000000, 64'h3FD0000000000000,
			64'h4000000000000000, 2'h0, 1'h0);
		`CHK("madd", 64'h400A000000000000, res)
		`CHK("madd cls", 5'h04, cls)
		run(fmau_pkg::FMAU_MSUB, 1'h0, 1'h0, 64'h3FF8000000000000, 64'h4006000000000000,
			64'h4000000000000000, 2'h0, 1'h0);
		`CHK("renorm", 64'h3FD0000000000000, res)
		$display("t_basic finished");
	endtask

	task automatic t_b2b();
		fmau_seq_inst.send('{fmau_pkg::FMAU_MSUB, 1'h0, 1'h0, 64'h3FF8000000000000,
			64'h3FD0000000000000, 64'h4000000000000000}, 2'h0, 1'h0);
		fmau_seq_inst.send('{fmau_pkg::FMAU_NMSUB, 1'h0, 1'h0, 64'h3FF8000000000000,
			64'h3FD0000000000000, 64'h4000000000000000}, 2'h0, 1'h0);
		#1;
		`CHK("msub", 64'h4006000000000000, res)
		fmau_seq_inst.idle();
		#1;
		`CHK("nmsub", 64'hC006000000000000, res)
		$display("t_b2b finished");
	endtask

	task automatic t_round();
		logic [63:0] up [4] = '{64'h3FF0000000000000, 64'h3FF0000000000000,
			64'h3FF0000020000000, 64'h3FF0000000000000};
		logic [63:0] dn [4] = '{64'h3FF0000000000000, 64'h3FEFFFFFE0000000,
			64'h3FF0000000000000, 64'h3FEFFFFFE0000000};
		for (int m = 0; m < 4; m++)
		begin
			run(fmau_pkg::FMAU_MADD, 1'h1, 1'h0, 64'h3FF0000000000000, 64'h3E60000000000000,
				64'h3FF0000000000000, m[1:0], 1'h0);
			`CHK("round up", up[m], res)
			run(fmau_pkg::FMAU_MADD, 1'h1, 1'h0, 64'h3FF0000000000000, 64'hBE60000000000000,
				64'h3FF0000000000000, m[1:0], 1'h0);
			`CHK("round dn", dn[m], res)
		end
		run(fmau_pkg::FMAU_MADD, 1'h0, 1'h0, 64'h3FF0000000000000, 64'h3E60000000000000,
			64'h3FF0000000000000, 2'h0, 1'h0);
		`CHK("double", 64'h3FF0000008000000, res)
		$display("t_round finished");
	endtask

	// Rounding the product first would cancel to zero here.
	task automatic t_fused();
		run(fmau_pkg::FMAU_MADD, 1'h0, 1'h0, 64'h3FF0000000400000, 64'hBFF0000000800000,
			64'h3FF0000000400000, 2'h0, 1'h0);
		`CHK("fused", 64'h3C30000000000000, res)
		$display("t_fused finished");
	endtask

	task automatic t_nan();
		run(fmau_pkg::FMAU_NMADD, 1'h0, 1'h0, 64'hFFF8000000000001, 64'h3FF0000000000000,
			64'h3FF0000000000000, 2'h0, 1'h0);
		`CHK("qnan", 64'hFFF8000000000001, res)
		run(fmau_pkg::FMAU_NMSUB, 1'h0, 1'h0, 64'hFFF0000000000001, 64'h3FF0000000000000,
			64'h3FF0000000000000, 2'h0, 1'h0);
		`CHK("snan", 64'hFFF8000000000001, res)
		`CHK("vxsnan", 1'h1, exc.vxsnan)
		run(fmau_pkg::FMAU_NMADD, 1'h0, 1'h1, 64'h7FF0000000000000, 64'h3FF0000000000000,
			64'h0, 2'h0, 1'h0);
		`CHK("defnan", 64'h7FF8000000000000, res)
		`CHK("vximz", 6'h10, exc)
		`CHK("nan cls", 5'h11, cls)
		`CHK("cond inv", 4'hA, cond)
		$display("t_nan finished");
	endtask

	task automatic t_trap();
		run(fmau_pkg::FMAU_NMADD, 1'h0, 1'h0, 64'h3FF8000000000000, 64'h3FD0000000000000,
			64'h4000000000000000, 2'h0, 1'h0);
		`CHK("nmadd cls", 5'h08, cls)
		run(fmau_pkg::FMAU_NMADD, 1'h0, 1'h1, 64'h7FF0000000000000, 64'h3FF0000000000000,
			64'h0, 2'h0, 1'h1);
		`CHK("trap we", 2'h0, {dest_we, class_we})
		`CHK("trap cls", 5'h08, cls)
		`CHK("trap cond", 5'h1E, {cr_we, cond})
		run(fmau_pkg::FMAU_MADD, 1'h0, 1'h0, 64'h3FF8000000000000, 64'h3FD0000000000000,
			64'h4000000000000000, 2'h0, 1'h1);
		`CHK("no rec", 5'h0E, {cr_we, cond})
		$display("t_trap finished");
	endtask

	// Overflow, flush to zero, exact cancellation, inf minus inf, single NaN payload.
	task automatic t_edge();
		run(fmau_pkg::FMAU_MADD, 1'h0, 1'h0, 64'h7FE0000000000000, 64'h0,
			64'h4000000000000000, 2'h0, 1'h0);
		`CHK("ovf inf", 64'h7FF0000000000000, res)
		`CHK("ovf cls", 5'h05, cls)
		`CHK("ovf exc", 6'h05, exc)
		run(fmau_pkg::FMAU_NMADD, 1'h0, 1'h0, 64'h7FE0000000000000, 64'h0,
			64'h4000000000000000, 2'h1, 1'h0);
		`CHK("ovf max", 64'hFFEFFFFFFFFFFFFF, res)
		`CHK("ovf max cls", 5'h08, cls)
		run(fmau_pkg::FMAU_MADD, 1'h0, 1'h0, 64'h0010000000000000, 64'h0,
			64'h3FE0000000000000, 2'h0, 1'h0);
		`CHK("unf", 64'h0, res)
		`CHK("unf exc", 6'h03, exc)
		run(fmau_pkg::FMAU_MSUB, 1'h0, 1'h0, 64'h3FF0000000000000, 64'h3FF0000000000000,
			64'h3FF0000000000000, 2'h3, 1'h0);
		`CHK("zero ninf", 64'h8000000000000000, res)
		`CHK("nzero cls", 5'h12, cls)
		run(fmau_pkg::FMAU_NMSUB, 1'h0, 1'h0, 64'h3FF0000000000000, 64'h3FF0000000000000,
			64'h3FF0000000000000, 2'h3, 1'h0);
		`CHK("neg zero", 64'h0, res)
		`CHK("pzero cls", 5'h02, cls)
		run(fmau_pkg::FMAU_MSUB, 1'h0, 1'h0, 64'h7FF0000000000000, 64'h7FF0000000000000,
			64'h3FF0000000000000, 2'h0, 1'h0);
		`CHK("inf-inf", 64'h7FF8000000000000, res)
		`CHK("vxisi", 6'h08, exc)
		run(fmau_pkg::FMAU_MADD, 1'h1, 1'h0, 64'h7FF80000FFFFFFFF, 64'h3FF0000000000000,
			64'h3FF0000000000000, 2'h0, 1'h0);
		`CHK("sgl nan", 64'h7FF80000E0000000, res)
		$display("t_edge finished");
	endtask

	initial
	begin
		repeat (3) @(posedge clk);
		srst <= 1'h0;
		#1;
		`CHK("reset outputs", 83'h0, {done, res, dest_we, cls, class_we, cond, cr_we, exc})
		t_basic();
		t_b2b();
		t_round();
		t_fused();
		t_nan();
		t_trap();
		t_edge();
		end_sim();
	end
endmodule
